/* File: rtl/swc_pkg.sv */
/*
  swc_pkg: shared constants and types for the standby wake serial command
  handler. Assumes a single 125 MHz core clock and 8N1 serial framing.
*/
package swc_pkg;
  // ==========================================================
  // clock and serial timing
  localparam int unsigned CLK_HZ = 125_000_000;
  // a fast link keeps each four-character exchange short
  localparam int unsigned BAUD = 1_000_000;
  localparam int unsigned BIT_CYCLES = CLK_HZ / BAUD;
  localparam int unsigned HALF_CYCLES = BIT_CYCLES / 2;
  localparam int unsigned CNT_W = 16;
  // settle time after wake before the receiver is trusted, in ns
  localparam int unsigned SETTLE_NS = 1000;
  localparam int unsigned SETTLE_CYCLES = (SETTLE_NS * 125 + 999) / 1000;
  // indicator on time before returning to standby, in ns
  localparam int unsigned HOLD_NS = 1000;
  localparam int unsigned HOLD_CYCLES = (HOLD_NS * 125) / 1000;

  // ==========================================================
  // four character ascii commands, first character in top byte
  localparam logic [31:0] INDICATOR_ON_COMMAND = 32'h434d_4f4e;
  localparam logic [31:0] RESEND_REQUEST_COMMAND = 32'h434d_5245;
  localparam logic [31:0] RECEIVE_DONE_REPLY = 32'h434d_5256;
  localparam logic [2:0] CMD_CHARS = 3'h4;

  // ==========================================================
  // reset values
  localparam logic INDICATOR_RESET = 1'b0;
  localparam logic TXD_IDLE = 1'b1;

  // ==========================================================
  // types
  typedef enum logic [3:0] {
    ST_INIT = 4'h0,
    ST_STANDBY = 4'h1,
    ST_SETTLE = 4'h3,
    ST_SEND_RESEND = 4'h2,
    ST_WAIT_CMD = 4'h6,
    ST_SEND_DONE = 4'h7,
    ST_SHOW = 4'h5,
    ST_RETURN = 4'h4
  } swc_state_type;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } swc_byte_type;
endpackage

/* File: rtl/swc_uart_tx.sv */
/*
  swc_uart_tx: 8N1 serial transmitter, one byte per start pulse.
  Assumes the caller waits for idle before pulsing start.
*/
`timescale 1ns/1ns
module swc_uart_tx (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire swc_pkg::swc_byte_type tx_byte,
  output logic tx_idle,
  output logic txd
);
  logic [9:0] shift_reg, shift_next;
  logic [3:0] bits_reg, bits_next;
  logic [15:0] cnt_reg, cnt_next;
  logic txd_reg, txd_next;

  // ==========================================================
  // shifter: start bit, eight data bits lsb first, stop bit
  always_comb begin
    shift_next = shift_reg;
    bits_next = bits_reg;
    cnt_next = cnt_reg;
    txd_next = txd_reg;
    if (bits_reg == 4'h0) begin
      txd_next = swc_pkg::TXD_IDLE;
      if (tx_byte.valid) begin
        shift_next = {1'b1, tx_byte.data, 1'b0};
        bits_next = 4'ha;
        cnt_next = 16'h0000;
        txd_next = 1'b0;
      end
    end else if (cnt_reg == 16'(swc_pkg::BIT_CYCLES - 1)) begin
      cnt_next = 16'h0000;
      shift_next = {1'b1, shift_reg[9:1]};
      bits_next = bits_reg - 4'h1;
      txd_next = (bits_reg == 4'h1) ? swc_pkg::TXD_IDLE : shift_reg[1];
    end else begin
      cnt_next = cnt_reg + 16'h0001;
    end
  end

  // registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg <= 10'h3ff;
      bits_reg <= 4'h0;
      cnt_reg <= 16'h0000;
      txd_reg <= 1'b1;
    end else begin
      shift_reg <= shift_next;
      bits_reg <= bits_next;
      cnt_reg <= cnt_next;
      txd_reg <= txd_next;
    end
  end

  // idle must not look at the start request, or the caller's request
  // and this flag would chase each other in a zero-delay loop
  assign tx_idle = (bits_reg == 4'h0);
  assign txd = txd_reg;
endmodule

/* File: rtl/swc_handler.sv */
/*
  swc_handler: sleeps in standby watching the shared receive pin as a wake
  interrupt, wakes on traffic, asks the host to resend, checks the command,
  replies, lights the indicator and returns to standby.
  Assumes an asynchronous 8N1 host link and a 125 MHz core clock.
*/
// Behaviour
// - at power-up arm wake interrupt, enter standby
// - pin activity in standby wakes the device
// - indicator on immediately on waking
// - enable serial, pin becomes receive input
// - send resend request once receiver ready
// - send receive-done reply after full command
// - indicator on after acknowledging command
// - indicator off, pin to wake, standby
// - wait forever for resend, no timeout
`timescale 1ns/1ns
module swc_handler (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic shared_wake_receive_pin,
  output logic txd,
  output logic status_indicator,
  output logic standby,
  output logic external_wake_interrupt,
  output logic pin_is_serial_receive
);
  // ==========================================================
  // pin synchroniser, two flops before any logic
  logic pin_meta_reg, pin_sync_reg, pin_prev_reg;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_reg <= 1'b1;
      pin_sync_reg <= 1'b1;
      pin_prev_reg <= 1'b1;
    end else begin
      pin_meta_reg <= shared_wake_receive_pin;
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end
  logic pin_fall;
  assign pin_fall = pin_prev_reg && !pin_sync_reg;

  // ==========================================================
  // receiver: samples mid bit, only while the sequencer waits for a command
  logic rx_en;
  logic [3:0] rbits_reg, rbits_next;
  logic [15:0] rcnt_reg, rcnt_next;
  logic [7:0] rshift_reg, rshift_next;
  swc_pkg::swc_byte_type rx_reg, rx_next;

  always_comb begin
    rbits_next = rbits_reg;
    rcnt_next = rcnt_reg;
    rshift_next = rshift_reg;
    rx_next = '0;
    if (!rx_en) begin
      rbits_next = 4'h0;
    end else if (rbits_reg == 4'h0) begin
      if (pin_fall) begin
        rbits_next = 4'ha;
        rcnt_next = 16'(swc_pkg::HALF_CYCLES);
      end
    end else if (rcnt_reg == 16'h0000) begin
      rcnt_next = 16'(swc_pkg::BIT_CYCLES - 1);
      rbits_next = rbits_reg - 4'h1;
      if (rbits_reg == 4'ha && pin_sync_reg) begin
        rbits_next = 4'h0; // false start, glitch rejected
      end else if (rbits_reg == 4'h1) begin
        // framing error drops the byte rather than corrupt the match
        rx_next.valid = pin_sync_reg;
        rx_next.data = rshift_reg;
      end else if (rbits_reg != 4'ha) begin
        rshift_next = {pin_sync_reg, rshift_reg[7:1]};
      end
    end else begin
      rcnt_next = rcnt_reg - 16'h0001;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rbits_reg <= 4'h0;
      rcnt_reg <= 16'h0000;
      rshift_reg <= 8'h00;
      rx_reg <= '0;
    end else begin
      rbits_reg <= rbits_next;
      rcnt_reg <= rcnt_next;
      rshift_reg <= rshift_next;
      rx_reg <= rx_next;
    end
  end

  // ==========================================================
  // transmitter
  swc_pkg::swc_byte_type tx_byte;
  logic tx_idle;
  swc_uart_tx i_swc_uart_tx (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .tx_byte(tx_byte),
    .tx_idle(tx_idle),
    .txd(txd)
  );

  // picks character idx of a four-character command, top byte first
  function automatic logic [7:0] cmd_char(input logic [31:0] cmd,
                                          input logic [2:0] idx);
    cmd_char = cmd[8'(31 - 8 * idx) -: 8];
  endfunction

  // ==========================================================
  // sequencer
  swc_pkg::swc_state_type state_reg, state_next;
  logic [15:0] wait_reg, wait_next;
  logic [2:0] idx_reg, idx_next;
  logic [31:0] cmd_reg, cmd_next;
  logic ind_reg, ind_next;
  logic sent_reg, sent_next;
  // settle time plus one full ten-bit frame of the lost wake character
  localparam logic [15:0] SETTLE_END =
    16'(swc_pkg::SETTLE_CYCLES + 10 * swc_pkg::BIT_CYCLES);

  always_comb begin
    state_next = state_reg;
    wait_next = wait_reg;
    idx_next = idx_reg;
    cmd_next = cmd_reg;
    ind_next = ind_reg;
    sent_next = 1'b0;
    tx_byte = '0;
    case (state_reg)
      swc_pkg::ST_INIT: begin
        state_next = swc_pkg::ST_STANDBY;
      end
      swc_pkg::ST_STANDBY: begin
        if (pin_fall) begin
          state_next = swc_pkg::ST_SETTLE;
          ind_next = 1'b1;
          wait_next = 16'h0000;
        end
      end
      swc_pkg::ST_SETTLE: begin
        // the wake character is lost; let its frame pass before listening
        if (wait_reg == SETTLE_END) begin
          state_next = swc_pkg::ST_SEND_RESEND;
          idx_next = 3'h0;
        end else begin
          wait_next = wait_reg + 16'h0001;
        end
      end
      swc_pkg::ST_SEND_RESEND: begin
        if (tx_idle && !sent_reg) begin
          tx_byte.valid = 1'b1;
          tx_byte.data = cmd_char(swc_pkg::RESEND_REQUEST_COMMAND, idx_reg);
          sent_next = 1'b1;
          if (idx_reg == swc_pkg::CMD_CHARS - 3'h1) begin
            state_next = swc_pkg::ST_WAIT_CMD;
            idx_next = 3'h0;
          end else begin
            idx_next = idx_reg + 3'h1;
          end
        end
      end
      swc_pkg::ST_WAIT_CMD: begin
        // no timeout: stays awake until a full indicator-on command arrives
        if (rx_reg.valid) begin
          cmd_next = {cmd_reg[23:0], rx_reg.data};
          if (idx_reg == swc_pkg::CMD_CHARS - 3'h1) begin
            idx_next = 3'h0;
            if ({cmd_reg[23:0], rx_reg.data} ==
                swc_pkg::INDICATOR_ON_COMMAND) begin
              state_next = swc_pkg::ST_SEND_DONE;
            end
          end else begin
            idx_next = idx_reg + 3'h1;
          end
        end
      end
      swc_pkg::ST_SEND_DONE: begin
        if (tx_idle && !sent_reg) begin
          tx_byte.valid = 1'b1;
          tx_byte.data = cmd_char(swc_pkg::RECEIVE_DONE_REPLY, idx_reg);
          sent_next = 1'b1;
          if (idx_reg == swc_pkg::CMD_CHARS - 3'h1) begin
            state_next = swc_pkg::ST_SHOW;
            wait_next = 16'h0000;
          end else begin
            idx_next = idx_reg + 3'h1;
          end
        end
      end
      swc_pkg::ST_SHOW: begin
        ind_next = 1'b1;
        // waits for the reply to leave the line before sleeping
        if (tx_idle && !sent_reg &&
            wait_reg == 16'(swc_pkg::HOLD_CYCLES)) begin
          state_next = swc_pkg::ST_RETURN;
        end else if (wait_reg != 16'(swc_pkg::HOLD_CYCLES)) begin
          wait_next = wait_reg + 16'h0001;
        end
      end
      swc_pkg::ST_RETURN: begin
        ind_next = 1'b0;
        state_next = swc_pkg::ST_STANDBY;
      end
      default: begin
        state_next = swc_pkg::ST_INIT;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= swc_pkg::ST_INIT;
      wait_reg <= 16'h0000;
      idx_reg <= 3'h0;
      cmd_reg <= 32'h0000_0000;
      ind_reg <= swc_pkg::INDICATOR_RESET;
      sent_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      wait_reg <= wait_next;
      idx_reg <= idx_next;
      cmd_reg <= cmd_next;
      ind_reg <= ind_next;
      sent_reg <= sent_next;
    end
  end

  // ==========================================================
  // pin function and status outputs
  assign rx_en = (state_reg == swc_pkg::ST_WAIT_CMD);
  assign pin_is_serial_receive = (state_reg != swc_pkg::ST_STANDBY) &&
                                 (state_reg != swc_pkg::ST_INIT);
  assign external_wake_interrupt = (state_reg == swc_pkg::ST_STANDBY) &&
                                   pin_fall;
  assign standby = (state_reg == swc_pkg::ST_STANDBY);
  assign status_indicator = ind_reg;
endmodule

/* File: dv/swc_handler_properties.sv */
/*
  swc_handler_properties: port checker for swc_handler.
  Assumes one core clock and an active low asynchronous reset.
*/
`timescale 1ns/1ns
module swc_handler_properties (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic shared_wake_receive_pin,
  input wire logic txd,
  input wire logic status_indicator,
  input wire logic standby,
  input wire logic external_wake_interrupt,
  input wire logic pin_is_serial_receive
);
  // ==========================================
  // helper
  logic [15:0] gap_reg;
  logic [15:0] gap_next;
  // cycles since wake, saturating so it cannot wrap
  always_comb begin
    gap_next = gap_reg;
    if (external_wake_interrupt) begin
      gap_next = 16'h0000;
    end else if (gap_reg != 16'hffff) begin
      gap_next = gap_reg + 16'h0001;
    end
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_reg <= 16'h0000;
    end else begin
      gap_reg <= gap_next;
    end
  end
  // ==========================================
  // assertions
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  init_standby_a: assert property ($rose(rst_n) |-> ##[0:2] standby)
    else $error("no standby after reset");
  wake_source_a: assert property (
    external_wake_interrupt |-> standby || $past(standby))
    else $error("wake outside standby");
  wake_leaves_a: assert property (
    external_wake_interrupt |-> ##[1:3] !standby)
    else $error("wake did not leave standby");
  lamp_on_wake_a: assert property (
    external_wake_interrupt |-> ##[1:2] status_indicator)
    else $error("indicator late after wake");
  pin_swap_a: assert property (
    external_wake_interrupt |-> ##[1:300] pin_is_serial_receive)
    else $error("pin not given to receiver");
  pin_exclusive_a: assert property (
    standby |-> !pin_is_serial_receive)
    else $error("receiver owns pin in standby");
  tx_quiet_a: assert property (standby |-> txd)
    else $error("txd active in standby");
  lamp_off_sleep_a: assert property (
    standby |-> !status_indicator)
    else $error("indicator lit in standby");
  lamp_held_a: assert property (
    $fell(status_indicator) |-> ##[0:3] standby)
    else $error("indicator dropped while awake");
  settle_gap_a: assert property (
    $fell(txd) |-> gap_reg >= 16'(swc_pkg::SETTLE_CYCLES))
    else $error("resend request before settle");
  wake_c: cover property (external_wake_interrupt);
  reply_c: cover property ($fell(txd) && !standby);
  back_c: cover property ($rose(standby) && !$rose(rst_n));
endmodule

bind swc_handler swc_handler_properties i_swc_handler_properties (
  .core_clk, .rst_n, .shared_wake_receive_pin, .txd, .status_indicator,
  .standby, .external_wake_interrupt, .pin_is_serial_receive
);

/* File: dv/swc_host_model.sv */
/*
  swc_host_model: host terminal on the 8N1 link; sends a word on kick,
  decodes replies and resends on request. Assumes the idle-high line.
*/
`timescale 1ns/1ns
module swc_host_model (
  input wire logic core_clk,
  input wire logic txd,
  input wire logic kick,
  input wire logic bad_first,
  output logic pin,
  output logic [31:0] last_word,
  output int words,
  output int sent
);
  localparam int BC = swc_pkg::BIT_CYCLES;
  logic [31:0] acc;
  logic [7:0] b;
  int nb;
  // ==========================================
  // sender: start, eight bits lsb first, stop
  task automatic tx_word(input logic [31:0] w);
    logic [9:0] f;
    for (int c = 3; c >= 0; c--) begin
      f = {1'b1, w[c*8 +: 8], 1'b0};
      for (int i = 0; i < 10; i++) begin
        pin <= f[i];
        repeat (BC) @(posedge core_clk);
      end
    end
    sent++;
  endtask
  initial begin
    pin = 1'b1;
    sent = 0;
    forever begin
      @(posedge kick);
      tx_word(swc_pkg::INDICATOR_ON_COMMAND);
      wait (last_word === swc_pkg::RESEND_REQUEST_COMMAND);
      // a broken word first only when the bench asks for it
      if (bad_first) begin
        tx_word(32'h434d_4f46);
      end
      tx_word(swc_pkg::INDICATOR_ON_COMMAND);
    end
  end
  // ==========================================
  // receiver: mid-bit sampling, four bytes to a word
  initial begin
    words = 0;
    nb = 0;
    forever begin
      @(negedge txd);
      repeat (BC / 2) @(posedge core_clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BC) @(posedge core_clk);
        b = {txd, b[7:1]};
      end
      repeat (BC) @(posedge core_clk);
      acc = {acc[23:0], b};
      nb++;
      if (nb % 4 == 0) begin
        last_word = acc;
        words++;
      end
    end
  end
endmodule

/* File: dv/swc_handler_test.sv */
/*
  swc_handler_test: wake, resend, wrong word, reply and return.
  Assumes swc_host_model on the link and the bound port checker.
*/
`timescale 1ns/1ns
module swc_handler_test;
  logic core_clk;
  logic rst_n;
  logic kick;
  logic bad_first;
  logic pin;
  logic txd;
  logic status_indicator;
  logic standby;
  logic external_wake_interrupt;
  logic pin_is_serial_receive;
  logic [31:0] last_word;
  int words;
  int sent;
  int num_errors = 0;
  int compares = 0;
  int cycles = 0;
  int n;
  swc_handler i_swc_handler (.core_clk, .rst_n,
    .shared_wake_receive_pin(pin), .txd, .status_indicator, .standby,
    .external_wake_interrupt, .pin_is_serial_receive);
  swc_host_model i_swc_host_model (.core_clk, .txd, .kick, .bad_first,
    .pin, .last_word, .words, .sent);
  // ==========================================
  // clock and hang guard; a full run is near 21.3k cycles
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      finish_test();
    end
  end
  // ==========================================
  // shared tasks
  task automatic step();
    @(posedge core_clk);
    #1;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ==========================================
  // scenarios
  task automatic t_power_up();
    repeat (6) step();
    rst_n = 1'b1;
    repeat (3) step();
    check(standby, 1);
    check(pin_is_serial_receive, 0);
    check(status_indicator, 0);
  endtask
  task automatic t_wake();
    kick = 1'b1;
    for (n = 0; n < 50 && external_wake_interrupt !== 1'b1; n++) step();
    check(external_wake_interrupt, 1);
    repeat (2) step();
    check(status_indicator, 1);
    check(standby, 0);
    for (n = 0; n < 300 && pin_is_serial_receive !== 1'b1; n++) step();
    check(pin_is_serial_receive, 1);
  endtask
  task automatic t_resend_wrong_word();
    int lows;
    lows = 0;
    for (n = 0; n < 20000 && words < 1; n++) step();
    check(last_word, swc_pkg::RESEND_REQUEST_COMMAND);
    for (n = 0; n < 20000 && sent < 2; n++) step();
    // a wrongly taken word would already be replying in this window
    for (n = 0; n < 3 * swc_pkg::BIT_CYCLES; n++) begin
      step();
      if (txd !== 1'b1) begin
        lows++;
      end
    end
    check(lows, 0);
    check(words, 1);
    check(status_indicator, 1);
    check(standby, 0);
  endtask
  task automatic t_reply_and_return();
    for (n = 0; n < 20000 && words < 2; n++) step();
    check(last_word, swc_pkg::RECEIVE_DONE_REPLY);
    check(status_indicator, 1);
    for (n = 0; n < 5000 && standby !== 1'b1; n++) step();
    check(standby, 1);
    check(status_indicator, 0);
    check(pin_is_serial_receive, 0);
  endtask
  initial begin
    rst_n = 1'b0;
    kick = 1'b0;
    bad_first = 1'b1;
    t_power_up();
    t_wake();
    t_resend_wrong_word();
    t_reply_and_return();
    finish_test();
  end
endmodule
